// ===== rtl/tpf_rx_path.sv
// Copper receive path: decode, descramble, align, check and forward to fiber
//
// Overview of operation
// - Turn the three-level equalizer output into a two-level NRZI stream.
// - Retime line bits on rising edges of the recovered symbol clock, sampled by the system clock.
// - Undo NRZI coding of the retimed copper bits into plain NRZ.
// - Gather serial NRZ bits into 5-bit code groups.
// - Descramble the copper receive groups before checking and forwarding.
// - Lock group boundary on J/K, then check each following group up to the next Idle group.
// - Each code violation pulses the active-low copper error LED.
// - Serialize descrambled groups into one bit stream for the fiber.
// - NRZI encode the fiber-bound serial stream.
// - Track link and receive activity per interface, and errors on the copper side only.
// - Copper transmitter sends fill while the fiber link is down.
// - Fiber transmitter sends fill while the copper link is down.
// - Halt select pin makes fill Halt symbols instead of Idle.
// - Link LEDs are static levels while the link is up.
// - Activity and error LEDs go through retriggerable one-shot stretchers.
// - Copper-to-fiber delay stays within 10 bit times, no elastic buffer.
// - Bypass strap caught after reset skips descrambling.
`timescale 1ns/1ns
`include "tpf_consts.svh"
module tpf_rx_path #(
  parameter int STRETCH_CYC = `TPF_STRETCH_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic copper_rx_clk,
  input  wire logic copper_mlt_pos,
  input  wire logic copper_mlt_neg,
  input  wire logic copper_signal_detect,
  input  wire logic fiber_signal_detect,
  input  wire logic fiber_rx_event,
  input  wire logic fiber_to_copper_nrzi,
  input  wire logic no_link_halt_select,
  input  wire logic scrambler_bypass_strap,
  output logic      fiber_tx_nrzi,
  output logic      copper_tx_nrzi,
  output logic      copper_link_led_n,
  output logic      fiber_link_led_n,
  output logic      copper_rx_activity_led_n,
  output logic      fiber_rx_activity_led_n,
  output logic      copper_error_led_n
);
  localparam int NS = `TPF_SYNC_BITS;

  tpf_pkg::tpf_pins_t pins_raw;
  tpf_pkg::tpf_pins_t sync1_ff;
  tpf_pkg::tpf_pins_t pins_s;
  logic               clk_prev_ff;
  logic [1:0]         mlt_prev_ff;
  logic               nrzi_ff;
  logic [10:0]        lfsr_ff;
  logic [5:0]         match_ff;
  logic               locked_ff;
  logic [9:0]         win_ff;
  logic [2:0]         bitcnt_ff;
  tpf_pkg::tpf_align_t align_ff;
  logic               err_ff;
  logic               fiber_tx_ff;
  logic               copper_tx_ff;
  logic [3:0]         div_ff;
  logic [2:0]         fill_idx_ff;
  logic               bypass_ff;
  logic [1:0]         strap_cnt_ff;
  logic               copper_led_ff;
  logic               fiber_led_ff;

  logic [1:0]         nxt_mlt_prev;
  logic               nxt_nrzi;
  logic [10:0]        nxt_lfsr;
  logic [5:0]         nxt_match;
  logic               nxt_locked;
  logic [9:0]         nxt_win;
  logic [2:0]         nxt_bitcnt;
  tpf_pkg::tpf_align_t nxt_align;
  logic               nxt_err;
  logic               nxt_fiber_tx;
  logic               nxt_copper_tx;
  logic [3:0]         nxt_div;
  logic [2:0]         nxt_fill_idx;
  logic               nxt_bypass;
  logic [1:0]         nxt_strap_cnt;

  logic               sym_edge;
  logic               fill_tick;
  logic               nrz_bit;
  logic               key_bit;
  logic               data_bit;
  logic               fill_bit;
  logic [4:0]         fill_code;
  logic [2:0]         led_trig;
  logic [2:0]         led_n;

  assign pins_raw = '{rx_clk: copper_rx_clk, mlt_pos: copper_mlt_pos, mlt_neg: copper_mlt_neg,
                      copper_sd: copper_signal_detect, fiber_sd: fiber_signal_detect,
                      fiber_rx_event: fiber_rx_event, halt_sel: no_link_halt_select,
                      bypass: scrambler_bypass_strap, f2c_nrzi: fiber_to_copper_nrzi};

  // Two-stage synchronizer on every pin; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sync1_ff[gi] <= 1'b0;
          pins_s[gi]   <= 1'b0;
        end else begin
          sync1_ff[gi] <= pins_raw[gi];
          pins_s[gi]   <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  function automatic logic tpf_bad_code(input logic [4:0] c);
    case (c)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19: tpf_bad_code = 1'b1;
      default: tpf_bad_code = 1'b0;
    endcase
  endfunction

  always_comb begin
    sym_edge  = pins_s.rx_clk && !clk_prev_ff;
    fill_tick = (div_ff == `TPF_FILL_DIV - 4'h1);
    nxt_div   = fill_tick ? 4'h0 : div_ff + 4'h1;
    fill_code = pins_s.halt_sel ? `TPF_CODE_HALT : `TPF_CODE_IDLE;
    fill_bit  = fill_code[3'(`TPF_FILL_LAST - fill_idx_ff)];
    nxt_fill_idx = fill_idx_ff;
    if (fill_tick) begin
      nxt_fill_idx = (fill_idx_ff == `TPF_FILL_LAST) ? 3'h0 : fill_idx_ff + 3'h1;
    end

    nxt_mlt_prev = mlt_prev_ff;
    nxt_nrzi     = nrzi_ff;
    nxt_lfsr     = lfsr_ff;
    nxt_match    = match_ff;
    nxt_locked   = locked_ff;
    nxt_win      = win_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_align    = align_ff;
    nxt_err      = 1'b0;
    nxt_fiber_tx = fiber_tx_ff;
    // level change on the three-level line toggles the NRZI level
    nxt_nrzi = nrzi_ff ^ ({pins_s.mlt_pos, pins_s.mlt_neg} != mlt_prev_ff);
    nrz_bit  = nxt_nrzi ^ nrzi_ff;
    if (!sym_edge) begin
      nxt_nrzi = nrzi_ff;
    end
    // key from taps 11 and 9
    key_bit  = lfsr_ff[10] ^ lfsr_ff[8];
    data_bit = bypass_ff ? nrz_bit : (nrz_bit ^ key_bit);

    if (sym_edge) begin
      nxt_mlt_prev = {pins_s.mlt_pos, pins_s.mlt_neg};
      // idle is all ones, so the inverted line bit is the key
      if (locked_ff) begin
        nxt_lfsr = {lfsr_ff[9:0], key_bit};
      end else begin
        nxt_lfsr  = {lfsr_ff[9:0], ~nrz_bit};
        nxt_match = (~nrz_bit == key_bit) ? match_ff + 6'h01 : 6'h00;
        nxt_locked = (nxt_match == `TPF_LOCK_MATCHES);
      end
      // the group shifter doubles as the serializer
      nxt_win    = {win_ff[8:0], data_bit};
      nxt_bitcnt = (bitcnt_ff == 3'h4) ? 3'h0 : bitcnt_ff + 3'h1;
      // boundary fixed at J/K, groups checked up to and including the next Idle
      case (align_ff)
        tpf_pkg::TPF_SEARCH: begin
          if (nxt_win == {`TPF_CODE_J, `TPF_CODE_K}) begin
            nxt_align  = tpf_pkg::TPF_ALIGNED;
            nxt_bitcnt = 3'h0;
          end
        end
        tpf_pkg::TPF_ALIGNED: begin
          if (bitcnt_ff == 3'h4) begin
            nxt_err = tpf_bad_code(nxt_win[4:0]);
            if (nxt_win[4:0] == `TPF_CODE_IDLE) begin
              nxt_align = tpf_pkg::TPF_SEARCH;
            end
          end
        end
        default: nxt_align = tpf_pkg::TPF_SEARCH;
      endcase
    end

    // five-bit delay then NRZI toward the fiber
    if (pins_s.copper_sd) begin
      if (sym_edge) begin
        nxt_fiber_tx = fiber_tx_ff ^ win_ff[4];
      end
    end else begin
      nxt_align  = tpf_pkg::TPF_SEARCH;
      nxt_locked = 1'b0;
      nxt_match  = 6'h00;
      if (fill_tick) begin
        nxt_fiber_tx = fiber_tx_ff ^ fill_bit;
      end
    end

    // copper transmitter fill while the fiber is down
    nxt_copper_tx = copper_tx_ff;
    if (!pins_s.fiber_sd) begin
      if (fill_tick) begin
        nxt_copper_tx = copper_tx_ff ^ fill_bit;
      end
    end else begin
      nxt_copper_tx = pins_s.f2c_nrzi;
    end

    // strap caught once the synchronizer has filled
    nxt_bypass    = bypass_ff;
    nxt_strap_cnt = strap_cnt_ff;
    if (strap_cnt_ff != 2'h3) begin
      nxt_strap_cnt = strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'h2) begin
        nxt_bypass = pins_s.bypass;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_ff   <= 1'b0;
      mlt_prev_ff   <= 2'h0;
      nrzi_ff       <= 1'b0;
      lfsr_ff       <= 11'h000;
      match_ff      <= 6'h00;
      locked_ff     <= 1'b0;
      win_ff        <= 10'h000;
      bitcnt_ff     <= 3'h0;
      align_ff      <= tpf_pkg::TPF_SEARCH;
      err_ff        <= 1'b0;
      fiber_tx_ff   <= 1'b0;
      copper_tx_ff  <= 1'b0;
      div_ff        <= 4'h0;
      fill_idx_ff   <= 3'h0;
      bypass_ff     <= 1'b0;
      strap_cnt_ff  <= 2'h0;
      copper_led_ff <= 1'b1;
      fiber_led_ff  <= 1'b1;
    end else begin
      clk_prev_ff   <= pins_s.rx_clk;
      mlt_prev_ff   <= nxt_mlt_prev;
      nrzi_ff       <= nxt_nrzi;
      lfsr_ff       <= nxt_lfsr;
      match_ff      <= nxt_match;
      locked_ff     <= nxt_locked;
      win_ff        <= nxt_win;
      bitcnt_ff     <= nxt_bitcnt;
      align_ff      <= nxt_align;
      err_ff        <= nxt_err;
      fiber_tx_ff   <= nxt_fiber_tx;
      copper_tx_ff  <= nxt_copper_tx;
      div_ff        <= nxt_div;
      fill_idx_ff   <= nxt_fill_idx;
      bypass_ff     <= nxt_bypass;
      strap_cnt_ff  <= nxt_strap_cnt;
      copper_led_ff <= ~pins_s.copper_sd;
      fiber_led_ff  <= ~pins_s.fiber_sd;
    end
  end

  // activity events per interface, error events for copper only
  assign led_trig = {err_ff, align_ff == tpf_pkg::TPF_ALIGNED, pins_s.fiber_rx_event};

  generate
    for (gi = 0; gi < 3; gi++) begin : g_led
      tpf_stretch #(
        .CYC (STRETCH_CYC)
      ) u_stretch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .trig    (led_trig[gi]),
        .led_n   (led_n[gi])
      );
    end
  endgenerate

  assign fiber_tx_nrzi            = fiber_tx_ff;
  assign copper_tx_nrzi           = copper_tx_ff;
  assign copper_link_led_n        = copper_led_ff;
  assign fiber_link_led_n         = fiber_led_ff;
  assign fiber_rx_activity_led_n  = led_n[0];
  assign copper_rx_activity_led_n = led_n[1];
  assign copper_error_led_n       = led_n[2];
endmodule // tpf_rx_path

// ===== rtl/tpf_consts.svh
// Constants of the copper-to-fiber receive path
`ifndef TPF_CONSTS_SVH
`define TPF_CONSTS_SVH
`define TPF_CODE_IDLE    5'h1F
`define TPF_CODE_J       5'h18
`define TPF_CODE_K       5'h11
`define TPF_CODE_HALT    5'h04
`define TPF_SYNC_BITS    9
`define TPF_LOCK_MATCHES 6'h1E
`define TPF_FILL_DIV     4'h8
`define TPF_FILL_LAST    3'h4
`define TPF_STRETCH_MS   40
`define TPF_CLK_HZ       25000000
`define TPF_STRETCH_CYC  ((`TPF_STRETCH_MS * `TPF_CLK_HZ) / 1000)
`endif

// ===== rtl/tpf_pkg.sv
// Types of the copper-to-fiber receive path
package tpf_pkg;
  typedef struct packed {
    logic rx_clk;
    logic mlt_pos;
    logic mlt_neg;
    logic copper_sd;
    logic fiber_sd;
    logic fiber_rx_event;
    logic halt_sel;
    logic bypass;
    logic f2c_nrzi;
  } tpf_pins_t;

  typedef enum logic [0:0] {
    TPF_SEARCH  = 1'b0,
    TPF_ALIGNED = 1'b1
  } tpf_align_t;
endpackage

// ===== rtl/tpf_stretch.sv
// Retriggerable one-shot that stretches an event onto an active-low LED
`timescale 1ns/1ns
module tpf_stretch #(
  parameter int CYC = 1000000
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      led_n
);
  localparam int W = $clog2(CYC + 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         led_n_ff;
  logic         nxt_led_n;

  generate
    if (CYC < 1) begin : g_bad
      $error("tpf_stretch needs CYC of at least one");
    end
  endgenerate

  always_comb begin
    // Every new event restarts the full stretch
    if (trig) begin
      nxt_cnt = W'(CYC);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = '0;
    end
    nxt_led_n = (nxt_cnt == '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      led_n_ff <= 1'b1;
    end else begin
      cnt_ff   <= nxt_cnt;
      led_n_ff <= nxt_led_n;
    end
  end

  assign led_n = led_n_ff;
endmodule // tpf_stretch

// ===== verification/tpf_rx_props.sv
// Port checker for the copper-to-fiber receive path
`timescale 1ns/1ns
module tpf_rx_props #(
  parameter int STRETCH_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic copper_rx_clk,
  input wire logic copper_mlt_pos,
  input wire logic copper_mlt_neg,
  input wire logic copper_signal_detect,
  input wire logic fiber_signal_detect,
  input wire logic fiber_rx_event,
  input wire logic fiber_to_copper_nrzi,
  input wire logic no_link_halt_select,
  input wire logic scrambler_bypass_strap,
  input wire logic fiber_tx_nrzi,
  input wire logic copper_tx_nrzi,
  input wire logic copper_link_led_n,
  input wire logic fiber_link_led_n,
  input wire logic copper_rx_activity_led_n,
  input wire logic fiber_rx_activity_led_n,
  input wire logic copper_error_led_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_fiber_fill_step;
    !copper_signal_detect [*8] ##0 $changed(fiber_tx_nrzi);
  endsequence
  sequence s_copper_fill_step;
    !fiber_signal_detect [*8] ##0 $changed(copper_tx_nrzi);
  endsequence
  a_copper_link_led: assert property (copper_signal_detect [*5] |=> !copper_link_led_n)
    else $error("copper link led dark with link up");
  a_fiber_link_led: assert property (!fiber_signal_detect [*5] |=> fiber_link_led_n)
    else $error("fiber link led lit with link down");
  a_quiet_line_hold: assert property ((copper_signal_detect && !copper_rx_clk) [*8] |=> $stable(fiber_tx_nrzi))
    else $error("fiber output moved without a symbol");
  a_fiber_fill_pace: assert property (s_fiber_fill_step |=> $stable(fiber_tx_nrzi) [*7])
    else $error("fiber fill bit shorter than eight cycles");
  a_copper_fill_pace: assert property (s_copper_fill_step |=> $stable(copper_tx_nrzi) [*7])
    else $error("copper fill bit shorter than eight cycles");
  a_copper_pass_lag: assert property (fiber_signal_detect [*6] |-> copper_tx_nrzi == $past(fiber_to_copper_nrzi, 3))
    else $error("copper output does not follow fiber stream");
  a_err_led_hold: assert property ((STRETCH_CYC >= 8) && $fell(copper_error_led_n) |=> !copper_error_led_n [*7])
    else $error("error led pulse too short");
  a_act_led_hold: assert property ($fell(copper_rx_activity_led_n) |=> !copper_rx_activity_led_n [*7])
    else $error("activity led pulse too short");
  a_fiber_act_led: assert property (fiber_rx_event [*5] |=> !fiber_rx_activity_led_n)
    else $error("fiber activity led dark while receiving");
endmodule // tpf_rx_props
bind tpf_rx_path tpf_rx_props #(.STRETCH_CYC(STRETCH_CYC)) i_props (.*);

// ===== verification/tpf_line_model.sv
// Copper link partner: three-level line with a framed symbol clock
`timescale 1ns/1ns
module tpf_line_model (
  input  wire logic        go,
  input  wire logic [63:0] pattern,
  output logic             rx_clk,
  output logic             mlt_pos,
  output logic             mlt_neg,
  output logic             busy
);
  logic [1:0] phase = 2'h0;
  initial rx_clk = 1'b0;
  initial busy = 1'b0;
  assign mlt_pos = (phase == 2'h1);
  assign mlt_neg = (phase == 2'h3);
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      if (pattern[i]) phase = phase + 2'h1;
      #160 rx_clk = 1'b1;
      #160 rx_clk = 1'b0;
    end
    busy = 1'b0;
  end
endmodule // tpf_line_model

// ===== verification/testbench.sv
// Self-checking bench for the copper-to-fiber receive path
`timescale 1ns/1ns
`define TPF_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module testbench;
  localparam int STRETCH = 20;
  typedef struct packed { logic c, f, h, e, cl, fl; int ft, ct; } tpf_row_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, csd = 1'b0, fsd = 1'b0, fev = 1'b0;
  logic f2c = 1'b0, halt = 1'b0, byp = 1'b0, go = 1'b0, fprev = 1'b0, cprev = 1'b0;
  logic rx_clk, mp, mn, busy, ftx, ctx, cled, fled, cact, fact, eled, err_seen, act_seen;
  int   fails = 0, compares = 0, ftog = 0, ctog = 0;
  logic [63:0] pat = {31'h7FFF_FFFF, 5'h18, 5'h11, 5'h0D, 5'h00, 5'h1F, 8'h00};
  // Idle long enough for the descrambler to lock, then J/K, a bad group and idle
  localparam logic [63:0] PLAIN = {43'h7FF_FFFF_FFFF, 5'h18, 5'h11, 5'h00, 5'h1F, 1'h0};
  // Scrambler seed is arbitrary but must not be zero
  logic [10:0] key = 11'h2C5;
  tpf_row_t rows [5] = '{'{0, 0, 0, 0, 1, 1, 5, 5}, '{0, 0, 1, 1, 1, 1, 1, 1},
    '{1, 1, 0, 0, 0, 0, 0, 5}, '{0, 1, 1, 1, 1, 0, 1, 5}, '{1, 0, 1, 0, 0, 1, 0, 1}};
  always #20 clk_sys = ~clk_sys;
  // Lands on falling edges of the system clock
  always #320 f2c = ~f2c;
  tpf_line_model i_line (.go(go), .pattern(pat),
    .rx_clk(rx_clk), .mlt_pos(mp), .mlt_neg(mn), .busy(busy));
  tpf_rx_path #(.STRETCH_CYC(STRETCH)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .copper_rx_clk(rx_clk),
    .copper_mlt_pos(mp), .copper_mlt_neg(mn), .copper_signal_detect(csd), .fiber_signal_detect(fsd),
    .fiber_rx_event(fev), .fiber_to_copper_nrzi(f2c), .no_link_halt_select(halt),
    .scrambler_bypass_strap(byp), .fiber_tx_nrzi(ftx), .copper_tx_nrzi(ctx), .copper_link_led_n(cled),
    .fiber_link_led_n(fled), .copper_rx_activity_led_n(cact), .fiber_rx_activity_led_n(fact),
    .copper_error_led_n(eled));
  // Sampled clear of both clock edges so counting never races the drivers
  always @(posedge clk_sys) begin
    #5;
    if (ftx !== fprev) ftog++;
    if (ctx !== cprev) ctog++;
    fprev = ftx;
    cprev = ctx;
    if (eled === 1'b0) err_seen = 1'b1;
    if (cact === 1'b0) act_seen = 1'b1;
  end
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    `TPF_CHK({ftx, ctx}, 2'b00)
    `TPF_CHK({cled, fled, cact, fact, eled}, 5'h1F)
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      @(negedge clk_sys);
      {csd, fsd, halt, fev} = {rows[i].c, rows[i].f, rows[i].h, rows[i].e};
      repeat (16) @(negedge clk_sys);
      ftog = 0;
      ctog = 0;
      repeat (40) @(negedge clk_sys);
      `TPF_CHK({cled, fled}, {rows[i].cl, rows[i].fl})
      `TPF_CHK(ftog, rows[i].ft)
      `TPF_CHK(ctog, rows[i].ct)
      `TPF_CHK(fact, !rows[i].e)
      $display("fill row %0d done", i);
    end
    {rst_n, byp, csd, fsd, halt, fev} = 6'h1C;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    {ftog, err_seen, act_seen} = '0;
    go = 1'b1;
    @(negedge clk_sys);
    for (int k = 0; k < 700 && busy; k++) @(negedge clk_sys);
    repeat (STRETCH + 16) @(negedge clk_sys);
    `TPF_CHK(ftog, 43)
    `TPF_CHK(act_seen, 1'b1)
    `TPF_CHK(err_seen, 1'b1)
    `TPF_CHK({cact, eled}, 2'b11)
    $display("copper stream test done");
    {rst_n, byp, go} = 3'b000;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    // Scramble the plain stream; the line model sends the top bit first
    for (int n = 63; n >= 0; n--) begin
      pat[n] = PLAIN[n] ^ key[10] ^ key[8];
      key    = {key[9:0], key[10] ^ key[8]};
    end
    repeat (6) @(negedge clk_sys);
    {err_seen, act_seen} = 2'b00;
    go = 1'b1;
    @(negedge clk_sys);
    for (int k = 0; k < 700 && busy; k++) @(negedge clk_sys);
    repeat (STRETCH + 16) @(negedge clk_sys);
    `TPF_CHK(act_seen, 1'b1)
    `TPF_CHK(err_seen, 1'b1)
    `TPF_CHK({cact, eled}, 2'b11)
    $display("scrambled stream test done");
    report_and_stop();
  end
endmodule // testbench
